// >>> rtl/ptt_timer.sv
// Purpose: periodic tick timer with clock select and watchdog source mux
// Assumes: source clocks arrive as one-cycle enables synchronous to clk_i
// Notes: register reads answer one cycle after the read strobe
//
// The plain strobed port was decided locally.
`include "ptt_defines.svh"
`default_nettype none
module ptt_timer
    import ptt_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [`PTT_ADDR_W-1:0] addr_i,
    input wire logic [`PTT_DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`PTT_DATA_W-1:0] rd_data_o,
    // source clock enables and system status
    input wire logic irc_en_i,
    input wire logic osc_en_i,
    input wire logic osc_up_flag_i,
    input wire logic stop_mode_i,
    // results
    output logic tick_o,
    output logic irq_o,
    output logic tick_src_o,
    output ptt_wd_src_t wdog_src_o,
    output logic wdog_restart_o
);

    ptt_state_t s;
    ptt_state_t next_s;

    // prescaler length minus one for a divider code
    function automatic logic [17:0] prescale_last(input logic dec, input logic [2:0] code);
        logic [17:0] len;
        len = 18'h00000;
        if (dec)
        begin
            case (code)
                3'h0: len = `PTT_DEC_0;
                3'h1: len = `PTT_DEC_1;
                3'h2: len = `PTT_DEC_2;
                3'h3: len = `PTT_DEC_3;
                3'h4: len = `PTT_DEC_4;
                3'h5: len = `PTT_DEC_5;
                3'h6: len = `PTT_DEC_6;
                3'h7: len = `PTT_DEC_7;
                default: len = `PTT_DEC_0;
            endcase
        end
        else
        begin
            len = 18'h00001 << (5'(code) + `PTT_BIN_BASE_EXP);
        end
        return len - 18'h00001;
    endfunction : prescale_last

    // register offset match
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : addr_hit

    // watchdog source from the two select bits
    function automatic ptt_wd_src_t wdog_src_of(input logic hi, input logic lo);
        ptt_wd_src_t src;
        src = PTT_WD_IRC;
        if (hi)
        begin
            src = PTT_WD_AUX;
        end
        else if (lo)
        begin
            src = PTT_WD_OSC;
        end
        return src;
    endfunction : wdog_src_of

    // effective watchdog source change between two select states
    function automatic logic wdog_moved(input logic hi_old, input logic lo_old,
        input logic hi_new, input logic lo_new);
        return (hi_new != hi_old) || (!hi_new && !hi_old && (lo_new != lo_old));
    endfunction : wdog_moved

    logic wr_clk_sel;
    logic wr_rate;
    logic restart;
    logic timer_off;
    logic halted;
    logic src_en;
    logic [17:0] pre_last;
    logic [3:0] mod_last;
    logic [7:0] clk_sel_rd;

    always_comb
    begin
        wr_clk_sel = wr_i && addr_hit(addr_i, `PTT_OFS_CLK_SEL);
        wr_rate = wr_i && addr_hit(addr_i, `PTT_OFS_RATE);
        timer_off = !s.rate[`PTT_RATE_DEC_BIT]
            && (s.rate[`PTT_RATE_PRE_LSB +: 3] == 3'h0);
        halted = stop_mode_i && !(s.pstop_sel && s.tick_sel && s.pstop_en);
        src_en = s.tick_sel ? osc_en_i : irc_en_i;
        pre_last = prescale_last(s.rate[`PTT_RATE_DEC_BIT], s.rate[`PTT_RATE_PRE_LSB +: 3]);
        mod_last = s.rate[`PTT_RATE_MOD_LSB +: 4];
        clk_sel_rd = 8'h00;
        clk_sel_rd[`PTT_CS_WDOG_LO_BIT] = s.wd_lo;
        clk_sel_rd[`PTT_CS_TICK_SRC_BIT] = s.tick_sel;
        clk_sel_rd[`PTT_CS_PSTOP_EN_BIT] = s.pstop_en;
        clk_sel_rd[`PTT_CS_WDOG_HI_BIT] = s.wd_hi;
        clk_sel_rd[`PTT_CS_PSTOP_SEL_BIT] = s.pstop_sel;

        next_s = s;
        next_s.tick = 1'b0;
        next_s.wd_restart = 1'b0;
        next_s.rd_data = 8'h00;

        if (wr_clk_sel)
        begin
            next_s.tick_sel = wr_data_i[`PTT_CS_TICK_SRC_BIT] && osc_up_flag_i;
            next_s.wd_lo = wr_data_i[`PTT_CS_WDOG_LO_BIT] && osc_up_flag_i;
            next_s.wd_hi = wr_data_i[`PTT_CS_WDOG_HI_BIT];
            next_s.pstop_en = wr_data_i[`PTT_CS_PSTOP_EN_BIT];
            next_s.pstop_sel = wr_data_i[`PTT_CS_PSTOP_SEL_BIT];
        end
        if (!osc_up_flag_i)
        begin
            next_s.tick_sel = 1'b0;
            next_s.wd_lo = 1'b0;
        end
        if (wr_rate)
        begin
            next_s.rate = wr_data_i;
        end

        // watchdog restart on a source change that matters
        next_s.wd_restart = wdog_moved(s.wd_hi, s.wd_lo, next_s.wd_hi, next_s.wd_lo);

        restart = wr_rate || (next_s.tick_sel != s.tick_sel);
        if (restart)
        begin
            next_s.pre_cnt = 18'h00000;
            next_s.mod_cnt = 4'h0;
        end
        else if (!timer_off && !halted && src_en)
        begin
            if (s.pre_cnt >= pre_last)
            begin
                next_s.pre_cnt = 18'h00000;
                if (s.mod_cnt >= mod_last)
                begin
                    next_s.mod_cnt = 4'h0;
                    next_s.tick = 1'b1;
                end
                else
                begin
                    next_s.mod_cnt = s.mod_cnt + 4'h1;
                end
            end
            else
            begin
                next_s.pre_cnt = s.pre_cnt + 18'h00001;
            end
        end

        // sticky status, new event wins over a clear
        if (wr_i && addr_hit(addr_i, `PTT_OFS_INT_STAT))
        begin
            next_s.int_stat = s.int_stat & ~wr_data_i;
        end
        next_s.int_stat[`PTT_INT_TICK_BIT] = next_s.int_stat[`PTT_INT_TICK_BIT]
            || next_s.tick;
        next_s.int_stat[7:1] = 7'h00;
        if (wr_i && addr_hit(addr_i, `PTT_OFS_INT_MASK))
        begin
            next_s.int_mask = wr_data_i & 8'h01;
        end

        if (rd_i)
        begin
            case (addr_i)
                `PTT_OFS_CLK_SEL: next_s.rd_data = clk_sel_rd;
                `PTT_OFS_RATE: next_s.rd_data = s.rate;
                `PTT_OFS_INT_STAT: next_s.rd_data = s.int_stat;
                `PTT_OFS_INT_MASK: next_s.rd_data = s.int_mask;
                `PTT_OFS_STATE: next_s.rd_data = {4'h0, timer_off, halted, s.tick_sel,
                    osc_up_flag_i};
                default: next_s.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s <= '0;
            s.rate <= `PTT_RATE_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    always_comb
    begin
        rd_data_o = s.rd_data;
        tick_o = s.tick;
        irq_o = |(s.int_stat & s.int_mask);
        tick_src_o = s.tick_sel;
        wdog_restart_o = s.wd_restart;
        wdog_src_o = wdog_src_of(s.wd_hi, s.wd_lo);
    end

endmodule : ptt_timer
`default_nettype wire

// >>> rtl/ptt_defines.svh
// Purpose: constants of the periodic tick timer and clock select block
// Assumes: 8-bit register port, 200 MHz system clock
// Notes: offsets are byte addresses on the register port
//
// How it works
// - tick source is rc when 0, oscillator when 1
// - tick source change restarts the tick period
// - tick source set only while oscillator up
// - oscillator down clears tick source select
// - watchdog source: rc, oscillator, or auxiliary rc
// - high select set: low bit changes ignored
// - high select clear: low change restarts watchdog
// - watchdog low select set only while oscillator up
// - oscillator down clears watchdog low select
// - stop halts counter unless pseudo-stop on oscillator
// - control always accessible; writes restart the period
// - bit 7 picks binary or decimal divider
// - binary codes 1 to 7 give 2^10..2^16
// - modulus multiplies period by field plus one
// - binary prescale zero switches timer off
// - decimal codes give 1k to 200k clocks
// - pseudo-stop enable and select bits together let tick continue on oscillator
`ifndef PTT_DEFINES_SVH
`define PTT_DEFINES_SVH

`define PTT_CLK_MHZ 200
`define PTT_ADDR_W 8
`define PTT_DATA_W 8

`define PTT_OFS_CLK_SEL 8'h09
`define PTT_OFS_RATE 8'h0b
`define PTT_OFS_INT_STAT 8'h10
`define PTT_OFS_INT_MASK 8'h11
`define PTT_OFS_STATE 8'h12

`define PTT_RATE_RESET 8'h00
`define PTT_RATE_DEC_BIT 7
`define PTT_RATE_PRE_LSB 4
`define PTT_RATE_MOD_LSB 0

`define PTT_CS_WDOG_LO_BIT 0
`define PTT_CS_TICK_SRC_BIT 1
`define PTT_CS_PSTOP_EN_BIT 3
`define PTT_CS_WDOG_HI_BIT 4
`define PTT_CS_PSTOP_SEL_BIT 6

`define PTT_INT_TICK_BIT 0

`define PTT_BIN_BASE_EXP 5'd9
`define PTT_DEC_0 18'd1000
`define PTT_DEC_1 18'd2000
`define PTT_DEC_2 18'd5000
`define PTT_DEC_3 18'd10000
`define PTT_DEC_4 18'd20000
`define PTT_DEC_5 18'd50000
`define PTT_DEC_6 18'd100000
`define PTT_DEC_7 18'd200000

`endif

// >>> rtl/ptt_pkg.sv
// Purpose: types of the periodic tick timer block
// Assumes: nothing beyond the defines header
// Notes: whole module state is one packed struct
`default_nettype none
package ptt_pkg;

    typedef enum logic [1:0] {
        PTT_WD_IRC = 2'b00,
        PTT_WD_OSC = 2'b01,
        PTT_WD_AUX = 2'b10
    } ptt_wd_src_t;

    typedef struct packed {
        logic [7:0] rate;
        logic tick_sel;
        logic wd_lo;
        logic wd_hi;
        logic pstop_sel;
        logic pstop_en;
        logic [7:0] int_stat;
        logic [7:0] int_mask;
        logic [17:0] pre_cnt;
        logic [3:0] mod_cnt;
        logic [7:0] rd_data;
        logic tick;
        logic wd_restart;
    } ptt_state_t;

endpackage : ptt_pkg
`default_nettype wire

// >>> test/ptt_asserts.sv
// Purpose: port checker of ptt_timer
// Assumes: ptt_pkg compiled first
// Notes: bound to every ptt_timer
`include "ptt_defines.svh"
`default_nettype none
module ptt_asserts
    import ptt_pkg::*;
(
    // watched ports
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rd_data_o,
    input wire logic osc_up_flag_i,
    input wire logic stop_mode_i,
    input wire logic tick_o,
    input wire logic irq_o,
    input wire logic tick_src_o,
    input wire ptt_wd_src_t wdog_src_o,
    input wire logic wdog_restart_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    sequence rate_wr_s;
        wr_i && addr_i == `PTT_OFS_RATE;
    endsequence
    sequence halted_s;
        (stop_mode_i && !tick_src_o) [*2];
    endsequence
    src_drop_a: assert property (!osc_up_flag_i |=> !tick_src_o)
        else $error("tick source kept without oscillator");
    lo_drop_a: assert property (!osc_up_flag_i |=> wdog_src_o != PTT_WD_OSC)
        else $error("watchdog on oscillator while it is down");
    wd_code_a: assert property (wdog_src_o inside {PTT_WD_IRC, PTT_WD_OSC, PTT_WD_AUX})
        else $error("bad watchdog source code");
    wd_change_a: assert property ($changed(wdog_src_o) |-> ##[0:1] wdog_restart_o)
        else $error("watchdog source change without restart");
    aux_hold_a: assert property ((wdog_src_o == PTT_WD_AUX) [*3] |-> !wdog_restart_o)
        else $error("watchdog restart while on auxiliary clock");
    stop_halt_a: assert property (halted_s |-> !tick_o)
        else $error("tick while halted in stop");
    tick_pulse_a: assert property (tick_o |=> !tick_o)
        else $error("tick longer than one cycle");
    irq_cause_a: assert property ($rose(irq_o) |-> tick_o || $past(tick_o) || $past(wr_i))
        else $error("interrupt without cause");
    rd_idle_a: assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
        else $error("read data outside read cycle");
    wr_restart_a: assert property (rate_wr_s |=> !tick_o [*8])
        else $error("tick too soon after rate write");
endmodule : ptt_asserts
bind ptt_timer ptt_asserts u_ptt_asserts (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .addr_i(addr_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rd_data_o(rd_data_o),
    .osc_up_flag_i(osc_up_flag_i),
    .stop_mode_i(stop_mode_i),
    .tick_o(tick_o),
    .irq_o(irq_o),
    .tick_src_o(tick_src_o),
    .wdog_src_o(wdog_src_o),
    .wdog_restart_o(wdog_restart_o)
);
`default_nettype wire

// >>> test/tb_ptt_timer.sv
// Purpose: self-checking bench of ptt_timer
// Assumes: source enables held as levels
// Notes: tick gaps counted in clk_i cycles
`include "ptt_defines.svh"
`default_nettype none
module tb_ptt_timer
    import ptt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wr_data_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic irc_en_i = 1'b1;
    logic osc_en_i = 1'b0;
    logic osc_up_flag_i = 1'b0;
    logic stop_mode_i = 1'b0;
    logic [7:0] rd_data_o;
    logic tick_o, irq_o, tick_src_o, wdog_restart_o;
    ptt_wd_src_t wdog_src_o;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    int ticks = 0;
    int n;
    logic [7:0] d;
    logic [7:0] rates [5] = '{8'h10, 8'h21, 8'h80, 8'h8f, 8'h90};
    int per [5] = '{1024, 4096, 1000, 16000, 2000};
    ptt_timer u_ptt_timer (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .irc_en_i(irc_en_i), .osc_en_i(osc_en_i), .osc_up_flag_i(osc_up_flag_i),
        .stop_mode_i(stop_mode_i), .tick_o(tick_o), .irq_o(irq_o),
        .tick_src_o(tick_src_o), .wdog_src_o(wdog_src_o), .wdog_restart_o(wdog_restart_o));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wr_data_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rd_data_o;
    endtask : rd
    task automatic wt(output int k);
        k = 0;
        do
        begin
            @(posedge clk_i);
            #1 k++;
        end
        while (!tick_o && k < 20000);
    endtask : wt
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(negedge clk_i)
    begin
        ticks += tick_o;
    end
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            errors++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(`PTT_OFS_RATE, d);
        chk("rate reset", 8'h00, d);
        rd(8'h3f, d);
        chk("unmapped", 8'h00, d);
        repeat (1100) @(posedge clk_i);
        chk("off ticks", 0, ticks);
        $display("off test done");
        wr(`PTT_OFS_INT_MASK, 8'h01);
        foreach (rates[i])
        begin
            wr(`PTT_OFS_RATE, rates[i]);
            rd(`PTT_OFS_RATE, d);
            chk("rate rd", rates[i], d);
            wt(n);
            wt(n);
            chk("period", per[i], n);
        end
        chk("irq", 1, irq_o);
        wr(`PTT_OFS_INT_STAT, 8'h01);
        #1 chk("irq clear", 0, irq_o);
        $display("rate test done");
        wt(n);
        repeat (500) @(posedge clk_i);
        stop_mode_i <= 1'b1;
        repeat (3000) @(posedge clk_i);
        stop_mode_i <= 1'b0;
        wt(n);
        chk("stop rest", 1500, n);
        $display("stop test done");
        wr(`PTT_OFS_CLK_SEL, 8'h03);
        rd(`PTT_OFS_CLK_SEL, d);
        chk("sel refused", 8'h00, d);
        osc_up_flag_i <= 1'b1;
        wr(`PTT_OFS_CLK_SEL, 8'h01);
        #1 chk("wdog osc", PTT_WD_OSC, wdog_src_o);
        chk("wdog restart", 1, wdog_restart_o);
        irc_en_i <= 1'b0;
        osc_en_i <= 1'b1;
        wr(`PTT_OFS_CLK_SEL, 8'h03);
        wt(n);
        wt(n);
        chk("osc period", 2000, n);
        wr(`PTT_OFS_CLK_SEL, 8'h4a);
        stop_mode_i <= 1'b1;
        wt(n);
        wt(n);
        chk("pstop run", 2000, n);
        stop_mode_i <= 1'b0;
        $display("pseudo-stop test done");
        wr(`PTT_OFS_CLK_SEL, 8'h13);
        wr(`PTT_OFS_CLK_SEL, 8'h12);
        #1 chk("lo ignored", 0, wdog_restart_o);
        wr(`PTT_OFS_CLK_SEL, 8'h13);
        #1 chk("wdog aux", PTT_WD_AUX, wdog_src_o);
        osc_up_flag_i <= 1'b0;
        rd(`PTT_OFS_CLK_SEL, d);
        chk("osc lost", 8'h10, d);
        chk("src rc", 0, tick_src_o);
        n = ticks;
        repeat (2500) @(posedge clk_i);
        chk("rc idle", n, ticks);
        $display("clock select test done");
        end_of_test();
    end
endmodule : tb_ptt_timer
`default_nettype wire
